// >>> include/dtc_timer_regs.vh
// Register map, field positions and reset values of the dual 8-bit timer block.
`ifndef DTC_TIMER_REGS_VH
`define DTC_TIMER_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define DTC_ADDR_W 8
`define DTC_OFF_CHAN1_CONTROL 8'h25
`define DTC_OFF_CHAN0_CONTROL 8'h33
`define DTC_OFF_CHAN0_COUNT 8'h32
`define DTC_OFF_CHAN0_COMPARE 8'h3c
`define DTC_OFF_CHAN1_COUNT 8'h24
`define DTC_OFF_CHAN1_COMPARE 8'h23
`define DTC_OFF_PIN_DIR 8'h37
`define DTC_OFF_FLAGS 8'h38

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define DTC_CTL_FORCE 7
`define DTC_CTL_MOD_EN 6
`define DTC_CTL_ACT_HI 5
`define DTC_CTL_ACT_LO 4
`define DTC_CTL_CLR_ON_MATCH 3
`define DTC_CTL_CLK_HI 2
`define DTC_CTL_CLK_LO 0

// ----------------------------------------------------------------------------
// Flag and pin direction fields
// ----------------------------------------------------------------------------
`define DTC_FLG_CH0_OVF 0
`define DTC_FLG_CH0_CMP 1
`define DTC_FLG_CH1_OVF 2
`define DTC_FLG_CH1_CMP 3
`define DTC_DIR_CH0 0
`define DTC_DIR_CH1 1

// ----------------------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------------------
`define DTC_RST_CONTROL 8'h00
`define DTC_RST_COUNT 8'h00
`define DTC_RST_COMPARE 8'h00
`define DTC_RST_FLAGS 4'h0
`define DTC_RST_DIR 2'h0
`define DTC_CNT_MAX 8'hff
`define DTC_CNT_MIN 8'h00
`define DTC_PRE_RST 10'h000

`endif

// >>> design/dtc_timer.v
// Dual 8-bit timer/counter with compare output, modulation and register port.
//
// Notes on behaviour
// - Writing force bit applies configured match action to the pin immediately.
// - Forced match sets no compare flag and never clears the counter.
// - Action bits written with force bit take effect from the next match or the next forced write.
// - Force bit reads zero and does nothing in modulation mode.
// - Match actions reach the pin only when its direction bit selects output.
// - Control bit 6 selects modulation mode; clearing it restores normal counting.
// - Normal mode actions: 00 disconnect, 01 toggle, 10 low, 11 high.
// - Clear-on-match zeroes counter one cycle after match in normal mode.
// - Modulation: clear-on-match low counts up/down, high wraps at maximum.
// - Channel 0 clocks: stop, clock, /8, /64, /256, /1024, pin fall, pin rise.
// - Channel 1 clocks: stop, source, /8, /32, /64, /128, /256, /1024.
// - External pin edges count even while the pin is driven as output.
// - Counters are 8-bit read/write, up in normal and wrapping modulation, up/down in up/down modulation.
// - After a counter write, counting resumes on the next timer clock.
// - A counter write blocks compare matches in the next timer clock.
// - Compare register checked every count; flag set two cycles after match.
// - Up/down modulation gives a phase-correct glitch-free 8-bit waveform.
// - Wrapping modulation gives twice the up/down waveform frequency.
// - Modulation actions: up/down 10 clear up set down; wrap 10 clear match set overflow.
// - Modulation compare writes buffer until counter maximum; reads return last write.
// - Up/down overflow flag sets on leaving zero; wrapping as in normal.
// - Channel 1 source clock is the main system clock by default.
`timescale 1ns/10ps
`include "dtc_timer_regs.vh"

// ----------------------------------------------------------------------------
// One timer channel: prescaler, counter, compare unit and pin logic
// ----------------------------------------------------------------------------
module dtc_chan #(
    parameter IS_CH0 = 1
) (
    input wire sys_clk_in,
    input wire resetn_in,
    input wire wr_ctrl_in,
    input wire wr_cnt_in,
    input wire wr_cmp_in,
    input wire [7:0] wdata_in,
    input wire pin_dir_in,
    input wire ext_in,
    output reg [7:0] ctrl_out,
    output reg [7:0] cnt_out,
    output reg [7:0] cmp_out,
    output reg pin_out,
    output reg pin_oe_out,
    output reg ovf_set_out,
    output reg cmp_set_out
);
    reg [9:0] pre_reg;
    reg [7:0] cmp_act_reg;
    reg ext_prev_reg;
    reg down_reg;
    reg block_reg;
    reg tick;
    reg match;
    reg [7:0] cnt_next;
    reg ovf_ev;
    reg pin_next;
    wire mod_en;
    wire clr_match;
    wire [1:0] act;
    wire [2:0] clk_sel;

    assign mod_en = ctrl_out[`DTC_CTL_MOD_EN];
    assign clr_match = ctrl_out[`DTC_CTL_CLR_ON_MATCH];
    assign act = ctrl_out[`DTC_CTL_ACT_HI:`DTC_CTL_ACT_LO];
    assign clk_sel = ctrl_out[`DTC_CTL_CLK_HI:`DTC_CTL_CLK_LO];

    // Prescaler runs free; each tap yields a one-cycle enable, never a clock.
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pre_reg <= `DTC_PRE_RST;
            ext_prev_reg <= 1'b0;
        end else begin
            pre_reg <= pre_reg + 10'h001;
            ext_prev_reg <= ext_in;
        end
    end

    // Timer clock enable from the clock select code.
    always @* begin
        tick = 1'b0;
        if (IS_CH0 != 0) begin
            case (clk_sel)
                3'h0: tick = 1'b0;
                3'h1: tick = 1'b1;
                3'h2: tick = (pre_reg[2:0] == 3'h7);
                3'h3: tick = (pre_reg[5:0] == 6'h3f);
                3'h4: tick = (pre_reg[7:0] == 8'hff);
                3'h5: tick = (pre_reg[9:0] == 10'h3ff);
                3'h6: tick = ext_prev_reg & ~ext_in;
                3'h7: tick = ~ext_prev_reg & ext_in;
                default: tick = 1'b0;
            endcase
        end else begin
            // The source is always the main clock; no crystal domain here.
            case (clk_sel)
                3'h0: tick = 1'b0;
                3'h1: tick = 1'b1;
                3'h2: tick = (pre_reg[2:0] == 3'h7);
                3'h3: tick = (pre_reg[4:0] == 5'h1f);
                3'h4: tick = (pre_reg[5:0] == 6'h3f);
                3'h5: tick = (pre_reg[6:0] == 7'h7f);
                3'h6: tick = (pre_reg[7:0] == 8'hff);
                3'h7: tick = (pre_reg[9:0] == 10'h3ff);
                default: tick = 1'b0;
            endcase
        end
    end

    // Next count, match and overflow for the current timer clock.
    always @* begin
        match = tick & ~block_reg & (cnt_out == cmp_act_reg);
        cnt_next = cnt_out;
        ovf_ev = 1'b0;
        pin_next = pin_out;
        if (tick) begin
            if (!mod_en) begin
                if (clr_match && match) begin
                    cnt_next = `DTC_CNT_MIN;
                end else begin
                    cnt_next = cnt_out + 8'h01;
                    ovf_ev = (cnt_out == `DTC_CNT_MAX);
                end
                case (act)
                    2'b00: pin_next = pin_out;
                    2'b01: pin_next = match ? ~pin_out : pin_out;
                    2'b10: pin_next = match ? 1'b0 : pin_out;
                    2'b11: pin_next = match ? 1'b1 : pin_out;
                    default: pin_next = pin_out;
                endcase
            end else if (clr_match) begin
                // Wrapping setting: one pass per 256 counts, twice up/down rate.
                cnt_next = cnt_out + 8'h01;
                ovf_ev = (cnt_out == `DTC_CNT_MAX);
                // Overflow wins so a compare value of maximum holds the pin steady.
                if (act[1]) begin
                    if (ovf_ev) begin
                        pin_next = ~act[0];
                    end else if (match) begin
                        pin_next = act[0];
                    end
                end
            end else begin
                // Up/down setting: symmetric around the top gives phase-correct pulses.
                if (!down_reg) begin
                    cnt_next = (cnt_out == `DTC_CNT_MAX) ? 8'hfe : cnt_out + 8'h01;
                end else begin
                    cnt_next = (cnt_out == `DTC_CNT_MIN) ? 8'h01 : cnt_out - 8'h01;
                end
                ovf_ev = down_reg & (cnt_out == `DTC_CNT_MIN);
                if (act[1] && match) begin
                    pin_next = down_reg ? ~act[0] : act[0];
                end
            end
        end
    end

    // Counter, direction, compare registers and the write-side effects.
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_out <= `DTC_RST_CONTROL;
            cnt_out <= `DTC_RST_COUNT;
            cmp_out <= `DTC_RST_COMPARE;
            cmp_act_reg <= `DTC_RST_COMPARE;
            down_reg <= 1'b0;
            block_reg <= 1'b0;
            pin_out <= 1'b0;
            pin_oe_out <= 1'b0;
            ovf_set_out <= 1'b0;
            cmp_set_out <= 1'b0;
        end else begin
            ovf_set_out <= ovf_ev;
            cmp_set_out <= match;
            pin_oe_out <= pin_dir_in & (act != 2'b00 );
            if (wr_ctrl_in) begin
                // Force bit is never stored, so it reads back zero.
                ctrl_out <= {1'b0, wdata_in[6:0]};
            end
            // Forced action uses the old action bits and touches no counter.
            if (wr_ctrl_in && wdata_in[`DTC_CTL_FORCE] && !mod_en) begin
                case (act)
                    2'b00: pin_out <= pin_out;
                    2'b01: pin_out <= ~pin_out;
                    2'b10: pin_out <= 1'b0;
                    2'b11: pin_out <= 1'b1;
                    default: pin_out <= pin_out;
                endcase
            end else begin
                pin_out <= pin_next;
            end
            if (wr_cnt_in) begin
                cnt_out <= wdata_in;
                block_reg <= 1'b1;
            end else if (tick) begin
                cnt_out <= cnt_next;
                block_reg <= 1'b0;
            end
            if (tick && mod_en && !clr_match) begin
                if (!down_reg && cnt_out == `DTC_CNT_MAX) begin
                    down_reg <= 1'b1;
                end else if (down_reg && cnt_out == `DTC_CNT_MIN) begin
                    down_reg <= 1'b0;
                end
            end else if (!mod_en || clr_match) begin
                down_reg <= 1'b0;
            end
            if (wr_cmp_in) begin
                cmp_out <= wdata_in;
            end
            // Buffered load at the top keeps pulses whole on unsynchronised writes.
            if (wr_cmp_in && !mod_en) begin
                cmp_act_reg <= wdata_in;
            end else if (mod_en && tick && cnt_out == `DTC_CNT_MAX) begin
                cmp_act_reg <= cmp_out;
            end else if (!mod_en) begin
                cmp_act_reg <= cmp_out;
            end
        end
    end
endmodule

// ----------------------------------------------------------------------------
// Top: register port, flags, pin direction and two channels
// ----------------------------------------------------------------------------
module dtc_timer (
    input wire sys_clk_in,
    input wire resetn_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire external_count_input_in,
    output reg [7:0] rdata_out,
    output wire chan0_compare_pin_out,
    output wire chan0_compare_pin_oe_out,
    output wire chan1_compare_pin_out,
    output wire chan1_compare_pin_oe_out
);
    reg [3:0] flags_reg;
    reg [1:0] dir_reg;
    reg [3:0] flags_next;
    reg [7:0] rd_mux;
    wire [7:0] ctrl0;
    wire [7:0] ctrl1;
    wire [7:0] cnt0;
    wire [7:0] cnt1;
    wire [7:0] cmp0;
    wire [7:0] cmp1;
    wire ovf0;
    wire ovf1;
    wire mat0;
    wire mat1;

    dtc_chan #(.IS_CH0(1)) u_chan0 (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .wr_ctrl_in(wr_in && addr_in == `DTC_OFF_CHAN0_CONTROL),
        .wr_cnt_in(wr_in && addr_in == `DTC_OFF_CHAN0_COUNT),
        .wr_cmp_in(wr_in && addr_in == `DTC_OFF_CHAN0_COMPARE),
        .wdata_in(wdata_in),
        .pin_dir_in(dir_reg[`DTC_DIR_CH0]),
        .ext_in(external_count_input_in),
        .ctrl_out(ctrl0),
        .cnt_out(cnt0),
        .cmp_out(cmp0),
        .pin_out(chan0_compare_pin_out),
        .pin_oe_out(chan0_compare_pin_oe_out),
        .ovf_set_out(ovf0),
        .cmp_set_out(mat0)
    );

    dtc_chan #(.IS_CH0(0)) u_chan1 (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .wr_ctrl_in(wr_in && addr_in == `DTC_OFF_CHAN1_CONTROL),
        .wr_cnt_in(wr_in && addr_in == `DTC_OFF_CHAN1_COUNT),
        .wr_cmp_in(wr_in && addr_in == `DTC_OFF_CHAN1_COMPARE),
        .wdata_in(wdata_in),
        .pin_dir_in(dir_reg[`DTC_DIR_CH1]),
        .ext_in(1'b0),
        .ctrl_out(ctrl1),
        .cnt_out(cnt1),
        .cmp_out(cmp1),
        .pin_out(chan1_compare_pin_out),
        .pin_oe_out(chan1_compare_pin_oe_out),
        .ovf_set_out(ovf1),
        .cmp_set_out(mat1)
    );

    // Flags clear on a written one, but a new event in the same cycle wins.
    always @* begin
        flags_next = flags_reg;
        if (wr_in && addr_in == `DTC_OFF_FLAGS) begin
            flags_next = flags_reg & ~wdata_in[3:0];
        end
        flags_next = flags_next | {mat1, ovf1, mat0, ovf0};
    end

    // Read multiplexer; unmapped addresses read as zero.
    always @* begin
        case (addr_in)
            `DTC_OFF_CHAN0_CONTROL: rd_mux = ctrl0;
            `DTC_OFF_CHAN0_COUNT: rd_mux = cnt0;
            `DTC_OFF_CHAN0_COMPARE: rd_mux = cmp0;
            `DTC_OFF_CHAN1_CONTROL: rd_mux = ctrl1;
            `DTC_OFF_CHAN1_COUNT: rd_mux = cnt1;
            `DTC_OFF_CHAN1_COMPARE: rd_mux = cmp1;
            `DTC_OFF_PIN_DIR: rd_mux = {6'h00, dir_reg};
            `DTC_OFF_FLAGS: rd_mux = {4'h0, flags_reg};
            default: rd_mux = 8'h00;
        endcase
    end

    // Register port state; read data stands only in the cycle after the strobe.
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            flags_reg <= `DTC_RST_FLAGS;
            dir_reg <= `DTC_RST_DIR;
            rdata_out <= 8'h00;
        end else begin
            flags_reg <= flags_next;
            if (wr_in && addr_in == `DTC_OFF_PIN_DIR) begin
                dir_reg <= wdata_in[1:0];
            end
            rdata_out <= rd_in ? rd_mux : 8'h00;
        end
    end
endmodule

// >>> dv/dtc_timer_checker.sv
// Port-level assertions for the dual 8-bit timer.
`timescale 1ns/10ps
`include "dtc_timer_regs.vh"
module dtc_timer_checker (
    input logic sys_clk_in,
    input logic resetn_in,
    input logic [7:0] addr_in,
    input logic [7:0] wdata_in,
    input logic wr_in,
    input logic rd_in,
    input logic external_count_input_in,
    input logic [7:0] rdata_out,
    input logic chan0_compare_pin_out,
    input logic chan0_compare_pin_oe_out,
    input logic chan1_compare_pin_out,
    input logic chan1_compare_pin_oe_out
);
    // ------------------------------------------------------------------
    // Shadow copies of control and direction writes
    // ------------------------------------------------------------------
    logic [7:0] ctl0_reg;
    logic [7:0] ctl1_reg;
    logic [1:0] dir_reg;
    wire w0 = wr_in && addr_in == `DTC_OFF_CHAN0_CONTROL;
    wire w1 = wr_in && addr_in == `DTC_OFF_CHAN1_CONTROL;
    // Shadows load on the same edge as the design, so old values are seen at a write.
    always @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctl0_reg <= 8'h00;
            ctl1_reg <= 8'h00;
            dir_reg <= 2'h0;
        end else begin
            if (w0) ctl0_reg <= wdata_in;
            if (w1) ctl1_reg <= wdata_in;
            if (wr_in && addr_in == `DTC_OFF_PIN_DIR) dir_reg <= wdata_in[1:0];
        end
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    chk_force_reads_zero: assert property (
        rd_in && (addr_in == `DTC_OFF_CHAN0_CONTROL || addr_in == `DTC_OFF_CHAN1_CONTROL)
        |=> !rdata_out[7]) else $error("force bit read back as one");
    chk_read_idle_zero: assert property (
        !rd_in |=> rdata_out == 8'h00) else $error("read data outside read slot");
    chk_oe_follows_dir: assert property (
        chan0_compare_pin_oe_out == $past(dir_reg[0] && ctl0_reg[5:4] != 2'b00))
        else $error("pin enable does not follow direction and action");
    chk_stop_pin_hold: assert property (
        ctl0_reg[2:0] == 3'h0 && $past(ctl0_reg[2:0]) == 3'h0 && !wr_in
        |=> $stable(chan0_compare_pin_out)) else $error("stopped channel moved its pin");
    chk_force_level: assert property (
        w0 && wdata_in[7] && !ctl0_reg[6] && ctl0_reg[5] && dir_reg[0]
        |=> chan0_compare_pin_out == $past(ctl0_reg[4])) else $error("force level wrong");
    chk_force_ch1_level: assert property (
        w1 && wdata_in[7] && !ctl1_reg[6] && ctl1_reg[5] && dir_reg[1]
        |=> chan1_compare_pin_out == $past(ctl1_reg[4])) else $error("force level wrong");
    chk_force_toggle: assert property (
        w0 && wdata_in[7] && ctl0_reg[6:4] == 3'b001 && ctl0_reg[2:0] == 3'h0 && dir_reg[0]
        |=> chan0_compare_pin_out != $past(chan0_compare_pin_out))
        else $error("forced toggle did not toggle");
    chk_force_mod_ignored: assert property (
        w0 && wdata_in[7] && ctl0_reg[6] && ctl0_reg[2:0] == 3'h0
        |=> $stable(chan0_compare_pin_out)) else $error("force acted in modulation");
    cov_force: cover property (w0 && wdata_in[7] && !ctl0_reg[6]);
    cov_mod: cover property (w1 && wdata_in[6]);
    cov_read: cover property (rd_in && addr_in == `DTC_OFF_CHAN0_COUNT);
endmodule

bind dtc_timer dtc_timer_checker u_chk (.sys_clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .external_count_input_in, .rdata_out, .chan0_compare_pin_out,
    .chan0_compare_pin_oe_out, .chan1_compare_pin_out, .chan1_compare_pin_oe_out);

// >>> dv/tb_top.sv
// Self-checking bench for the dual 8-bit timer.
`timescale 1ns/10ps
`include "dtc_timer_regs.vh"
module tb_top;
    logic sys_clk_in;
    logic resetn_in;
    logic [7:0] addr_in;
    logic [7:0] wdata_in;
    logic wr_in;
    logic rd_in;
    logic external_count_input_in;
    logic [7:0] rdata_out;
    logic chan0_compare_pin_out;
    logic chan0_compare_pin_oe_out;
    logic chan1_compare_pin_out;
    logic chan1_compare_pin_oe_out;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [7:0] v0;
    logic [7:0] v1;
    logic [7:0] ctl [2] = '{`DTC_OFF_CHAN0_CONTROL, `DTC_OFF_CHAN1_CONTROL};
    logic [7:0] cnt [2] = '{`DTC_OFF_CHAN0_COUNT, `DTC_OFF_CHAN1_COUNT};
    logic [7:0] cmp [2] = '{`DTC_OFF_CHAN0_COMPARE, `DTC_OFF_CHAN1_COMPARE};
    int d0 [5] = '{1, 8, 64, 256, 1024};
    int d1 [7] = '{1, 8, 32, 64, 128, 256, 1024};
    dtc_timer dut (.sys_clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .external_count_input_in, .rdata_out, .chan0_compare_pin_out,
        .chan0_compare_pin_oe_out, .chan1_compare_pin_out, .chan1_compare_pin_oe_out);
    // ------------------------------------------------------------------
    // Clock, hang guard and shared tasks
    // ------------------------------------------------------------------
    initial begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    // The whole run needs about 8000 cycles, so 20000 means a hang.
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe, so sample just then.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(d, exp);
    endtask
    task automatic pin(input int ch, input logic exp);
        check({7'h0, ch ? chan1_compare_pin_out : chan0_compare_pin_out}, {7'h0, exp});
    endtask
    // Two count reads 2n cycles apart must differ by exactly two ticks.
    task automatic rate(input int ch, input logic [2:0] cs, input int n);
        wr(ctl[ch], {5'h0, cs});
        rd(cnt[ch], v0);
        repeat (2 * n - 2) @(posedge sys_clk_in);
        rd(cnt[ch], v1);
        check(v1 - v0, 8'h02);
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        resetn_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 8'h00;
        external_count_input_in = 1'b0;
        repeat (5) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        for (int c = 0; c < 2; c++) begin
            rc(ctl[c], `DTC_RST_CONTROL);
            rc(cnt[c], 8'h00);
            rc(cmp[c], 8'h00);
        end
        wr(8'h00, 8'hff);
        rc(8'h00, 8'h00);
        for (int c = 0; c < 2; c++) begin
            wr(cnt[c], 8'h5a);
            wr(cmp[c], 8'ha5);
            rc(cnt[c], 8'h5a);
            rc(cmp[c], 8'ha5);
        end
        // Forced matches on a stopped channel, both channels alike.
        wr(`DTC_OFF_PIN_DIR, 8'h03);
        for (int c = 0; c < 2; c++) begin
            wr(ctl[c], 8'h30);
            wr(ctl[c], 8'hb0);
            pin(c, 1'b1);
            wr(ctl[c], 8'ha0);
            pin(c, 1'b1);
            wr(ctl[c], 8'ha0);
            pin(c, 1'b0);
            wr(ctl[c], 8'h10);
            wr(ctl[c], 8'h90);
            pin(c, 1'b1);
            rc(ctl[c], 8'h10);
            rc(cnt[c], 8'h5a);
            wr(ctl[c], 8'h60);
            wr(ctl[c], 8'he0);
            pin(c, 1'b1);
            check({7'h0, c ? chan1_compare_pin_oe_out : chan0_compare_pin_oe_out}, 8'h01);
        end
        rc(`DTC_OFF_FLAGS, 8'h00);
        wr(`DTC_OFF_PIN_DIR, 8'h00);
        repeat (2) @(posedge sys_clk_in);
        #1;
        check({6'h0, chan1_compare_pin_oe_out, chan0_compare_pin_oe_out}, 8'h00);
        // Clear on match: with compare 9 the count repeats every ten cycles.
        wr(ctl[0], 8'h00);
        wr(cnt[0], 8'h00);
        wr(cmp[0], 8'h09);
        wr(ctl[0], 8'h09);
        rd(cnt[0], v0);
        repeat (8) @(posedge sys_clk_in);
        rd(cnt[0], v1);
        check(v1, v0);
        wr(ctl[0], 8'h08);
        rc(`DTC_OFF_FLAGS, 8'h02);
        wr(`DTC_OFF_FLAGS, 8'h0f);
        rc(`DTC_OFF_FLAGS, 8'h00);
        wr(cnt[0], 8'hfe);
        wr(ctl[0], 8'h01);
        repeat (3) @(posedge sys_clk_in);
        wr(ctl[0], 8'h00);
        rc(`DTC_OFF_FLAGS, 8'h01);
        wr(`DTC_OFF_FLAGS, 8'h0f);
        for (int i = 0; i < 5; i++) rate(0, 3'(i + 1), d0[i]);
        for (int i = 0; i < 7; i++) rate(1, 3'(i + 1), d1[i]);
        // External pin edges step channel 0 while its direction bit selects output (action 00, enable stays low).
        wr(`DTC_OFF_PIN_DIR, 8'h01);
        for (int m = 6; m < 8; m++) begin
            wr(ctl[0], m[7:0]);
            rd(cnt[0], v0);
            for (int t = 0; t < 6; t++) begin
                repeat (2) @(posedge sys_clk_in);
                external_count_input_in <= ~external_count_input_in;
            end
            repeat (3) @(posedge sys_clk_in);
            rd(cnt[0], v1);
            check(v1 - v0, 8'h03);
        end
        // Modulation: buffered compare, up/down period 510, wrapping period 256.
        wr(ctl[1], 8'h40);
        wr(cmp[1], 8'h33);
        rc(cmp[1], 8'h33);
        rc(ctl[1], 8'h40);
        wr(`DTC_OFF_FLAGS, 8'h0f);
        wr(ctl[1], 8'h41);
        rd(cnt[1], v0);
        repeat (508) @(posedge sys_clk_in);
        rd(cnt[1], v1);
        check(v1, v0);
        rd(`DTC_OFF_FLAGS, v0);
        check(v0 & 8'h04, 8'h04);
        wr(ctl[1], 8'h49);
        rd(cnt[1], v0);
        repeat (254) @(posedge sys_clk_in);
        rd(cnt[1], v1);
        check(v1, v0);
        // Modulation pin with compare 0x33 from a count of 0x10: wrap first, then up/down.
        wr(ctl[1], 8'h68);
        wr(cnt[1], 8'h10);
        wr(ctl[1], 8'h69);
        repeat (40) @(posedge sys_clk_in);
        #1 pin(1, 1'b0);
        repeat (210) @(posedge sys_clk_in);
        #1 pin(1, 1'b1);
        wr(ctl[1], 8'h60);
        wr(cnt[1], 8'h10);
        wr(ctl[1], 8'h61);
        repeat (40) @(posedge sys_clk_in);
        #1 pin(1, 1'b0);
        repeat (410) @(posedge sys_clk_in);
        #1 pin(1, 1'b1);
        report_and_stop();
    end
endmodule
